//--- shared/sb_consts.svh
// Purpose: offsets, field positions, reset values and codes of the store buffer block
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes: included by the package and the design
`ifndef SB_CONSTS_SVH
`define SB_CONSTS_SVH
`define SB_CTRL_OFF 8'h00
`define SB_STATUS_OFF 8'h04
`define SB_IRQ_CLR_OFF 8'h08
`define SB_CTRL_RST 32'h0000_0000
`define SB_ZERO_BIT 0
`define SB_EARLY_BIT 30
`define SB_ST_VALID_LSB 0
`define SB_ST_DRAIN_BIT 3
`define SB_ST_SLV_BIT 8
`define SB_ST_DEC_BIT 9
`define SB_RESP_OKAY 2'h0
`define SB_RESP_SLVERR 2'h2
`define SB_RESP_DECERR 2'h3
`define SB_SLOTS 3
`define SB_LINE_BYTES 32
`define SB_LINE_BITS 27
`define SB_AGE_MAX 2'h3
`endif

//--- shared/sb_pkg.sv
// Purpose: types of the merging store buffer block
// Assumes: three slots of one 256-bit line each
// Notes: numbers live in sb_consts.svh
`include "sb_consts.svh"
package sb_pkg;
  typedef enum logic [1:0] {RD_SLAVE, RD_RA_FILL, RD_WA_FILL, RD_PREFETCH} rd_kind_type;
  typedef struct packed {
    logic valid;
    logic drain;
    logic sec;
    logic wa;
    logic [1:0] age;
    logic [`SB_LINE_BITS-1:0] line;
    logic [`SB_LINE_BITS-1:0] last_line;
    logic last_sec;
    logic [`SB_LINE_BYTES-1:0] strb;
    logic [`SB_LINE_BYTES*8-1:0] data;
  } slot_type;
  typedef struct packed {
    slot_type [`SB_SLOTS-1:0] slot;
    logic early_en;
    logic zero_en;
    logic hw_pend;
    logic [7:0] hoff;
    logic [31:0] hrdata;
    logic hready;
    logic wr_ready;
    logic bresp_valid;
    logic [1:0] bresp;
    logic s_rvalid;
    logic [1:0] s_rresp;
    logic dv;
    logic [1:0] didx;
    logic dfill;
    logic dsec;
    logic [`SB_LINE_BITS-1:0] dline;
    logic [`SB_LINE_BYTES-1:0] dstrb;
    logic [`SB_LINE_BYTES*8-1:0] ddata;
    logic alloc;
    logic slv_irq;
    logic dec_irq;
    logic rd_haz;
    logic wr_haz;
  } state_type;
endpackage : sb_pkg

//--- testbench/l2_store_buffer_hazard_errors_test.sv
// Purpose: register, drain policy, merge, error return and hint tests of the store buffer
// Assumes: registered outputs, so values read right after an edge are those sampled there
// Notes: far-side masters keep attributes consistent and never mix zero-line with strong order
`timescale 1ns/1ns
`include "sb_consts.svh"
module l2_store_buffer_hazard_errors_test;
  import sb_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, wr_valid = 0, wr_ready, bresp_valid;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, wr_addr = 0, wr_strb = 0, rd_addr = 0, q, drain_strb;
  logic [1:0] htrans = 0, bresp, l3_rresp = 0, s_rresp, l3_bresp, drn_resp = 0, slv_resp = 0;
  logic [255:0] wr_data = 0, drain_data;
  logic [8:0] wat = 0;
  logic [3:0] rat = 0, lat = 4'h1;
  logic rd_valid = 0, l3_rvalid = 0, slv_go = 0, rd_hazard, wr_hazard, drain_valid, drain_ready, drain_secure;
  logic drain_fill, l3_bvalid, l3_b_slave, s_rvalid, alloc, slv_irq, dec_irq, cf, eh = 0, mh = 0;
  logic [26:0] drain_line, cl;
  logic [31:0] cs;
  logic [255:0] cd;
  rd_kind_type l3_rkind = RD_SLAVE;
  int fail_count = 0, total_checks = 0, nd = 0, nb = 0, ns = 0, na = 0, nh = 0, k;
  logic [1:0] lb, lr;
  always #10 hclk = ~hclk;
  store_buffer #(.WIDE_CMP(1'b0)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_secure(1'b0), .wr_data(wr_data), .wr_strb(wr_strb), .wr_device(wat[8]), .wr_strong(wat[7]),
    .wr_bufferable(wat[6]), .wr_cacheable(wat[5]), .write_allocate(wat[4]), .wr_locked(wat[3]),
    .wr_cfg(wat[2]), .wr_early(wat[1]), .wr_zero(wat[0]), .bresp_valid(bresp_valid), .bresp(bresp),
    .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_cacheable(rat[3]), .rd_strong(rat[2]), .rd_locked(rat[1]),
    .rd_cfg(rat[0]), .rslot_hit(1'b0), .evict_hit(eh), .mread_hit(mh), .rd_hazard(rd_hazard),
    .wr_hazard(wr_hazard), .drain_valid(drain_valid), .drain_ready(drain_ready), .drain_line(drain_line),
    .drain_secure(drain_secure), .drain_data(drain_data), .drain_strb(drain_strb), .drain_fill(drain_fill),
    .l3_bvalid(l3_bvalid), .l3_b_slave(l3_b_slave), .l3_bresp(l3_bresp), .l3_rvalid(l3_rvalid),
    .l3_rkind(l3_rkind), .l3_rresp(l3_rresp), .s_rvalid(s_rvalid), .s_rresp(s_rresp), .alloc(alloc),
    .l3_slave_error_irq(slv_irq), .l3_decode_error_irq(dec_irq));
  l3_model far (.hclk(hclk), .hresetn(hresetn), .drain_valid(drain_valid), .drain_ready(drain_ready),
    .l3_bvalid(l3_bvalid), .l3_b_slave(l3_b_slave), .l3_bresp(l3_bresp), .lat(lat), .drn_resp(drn_resp),
    .slv_go(slv_go), .slv_resp(slv_resp));
  always @(posedge hclk) begin
    if (drain_valid && drain_ready) begin
      nd++;
      cl = drain_line;
      cs = drain_strb;
      cd = drain_data;
      cf = drain_fill;
    end
    if (bresp_valid) begin
      nb++;
      lb = bresp;
    end
    if (s_rvalid) begin
      ns++;
      lr = s_rresp;
    end
    if (alloc) na++;
    if (rd_hazard || wr_hazard) nh++;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  task chk(input logic [255:0] s, input logic [255:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task hang(input int n);
    if (n >= 40) begin
      fail_count++;
      give_verdict;
    end
  endtask : hang
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    hang(n);
  endtask : ahb
  task wr(input logic [31:0] a, input logic [31:0] s, input logic [255:0] d, input logic [8:0] at);
    int n;
    n = 0;
    wr_valid <= 1'b1;
    wr_addr <= a;
    wr_strb <= s;
    wr_data <= d;
    wat <= at;
    do begin @(posedge hclk); n++; end while (wr_ready !== 1'b1 && n < 40);
    wr_valid <= 1'b0;
    @(posedge hclk);
    hang(n);
  endtask : wr
  task rq(input logic [31:0] a, input logic [3:0] at);
    rd_valid <= 1'b1;
    rd_addr <= a;
    rat <= at;
    @(posedge hclk);
    rd_valid <= 1'b0;
    cyc(6);
  endtask : rq
  task l3r(input rd_kind_type kd, input logic [1:0] r);
    l3_rvalid <= 1'b1;
    l3_rkind <= kd;
    l3_rresp <= r;
    @(posedge hclk);
    l3_rvalid <= 1'b0;
    cyc(3);
  endtask : l3r
  function automatic logic [31:0] ln(input int i);
    return 32'h0000_1000 + 32'(i * 32);
  endfunction : ln
  initial begin
    cyc(5);
    hresetn <= 1'b1;
    cyc(2);
    chk(hreadyout, 1'b1);
    chk({slv_irq, dec_irq, hresp}, 3'h0);
    ahb(0, `SB_CTRL_OFF, 0);
    chk(q, `SB_CTRL_RST);
    ahb(0, 8'h0C, 0);
    chk(q, 32'h0);
    ahb(1, `SB_CTRL_OFF, 32'h4000_0001);
    ahb(0, `SB_CTRL_OFF, 0);
    chk(q, 32'h4000_0001);
    ahb(1, `SB_CTRL_OFF, 32'h0);
    $display("test registers finished");
    wr(ln(0), 32'h0000_FFFF, {8{32'h1111_1111}}, 9'h040);
    cyc(6);
    chk({nb, lb}, {32'd1, `SB_RESP_OKAY});
    chk(nd, 0);
    wr(ln(0), 32'h0000_000F, {8{32'h2222_2222}}, 9'h040);
    wr(ln(0), 32'hFFFF_0000, {8{32'h3333_3333}}, 9'h040);
    cyc(6);
    chk(nd, 1);
    chk(cs, 32'hFFFF_FFFF);
    chk(cd, {{4{32'h3333_3333}}, {3{32'h1111_1111}}, 32'h2222_2222});
    $display("test merge finished");
    wr(ln(1), 32'h1, 0, 9'h060);
    wr(ln(2), 32'h1, 0, 9'h060);
    wr(ln(1), 32'h2, 0, 9'h060);
    wr(ln(3), 32'h1, 0, 9'h060);
    cyc(6);
    chk({nd, cl, 5'h0}, {32'd2, ln(2)});
    rq(32'h8000_0000, 4'h4);
    cyc(4);
    chk(nd, 4);
    for (int i = 0; i < 4; i++) begin
      wr(ln(4), 32'h1, 0, 9'h060);
      k = nd;
      rq((i == 3) ? (ln(4) ^ 32'h0100_0000) : 32'h8000_0000, (i == 3) ? 4'h8 : (4'h1 << i));
      chk(nd, k + 1);
    end
    chk(nh, 1);
    eh <= 1'b1;
    wr(ln(4), 32'hFFFF_FFFF, 0, 9'h060);
    eh <= 1'b0;
    cyc(4);
    chk(nh, 2);
    mh <= 1'b1;
    rq(32'h8000_0000, 4'h8);
    mh <= 1'b0;
    chk(nh, 3);
    $display("test drain causes finished");
    drn_resp <= `SB_RESP_DECERR;
    k = nd;
    wr(ln(5), 32'h1, 0, 9'h140);
    cyc(8);
    chk({nd, dec_irq, lb}, {k + 1, 1'b1, `SB_RESP_OKAY});
    cyc(10);
    chk(dec_irq, 1'b1);
    ahb(1, `SB_IRQ_CLR_OFF, 32'h0000_0200);
    drn_resp <= `SB_RESP_SLVERR;
    cyc(2);
    chk(dec_irq, 1'b0);
    k = nb;
    wr(ln(6), 32'h1, 0, 9'h100);
    cyc(8);
    chk({nb, slv_irq}, {k, 1'b1});
    slv_resp <= `SB_RESP_SLVERR;
    slv_go <= 1'b1;
    @(posedge hclk);
    slv_go <= 1'b0;
    cyc(4);
    chk({nb, lb}, {k + 1, `SB_RESP_SLVERR});
    ahb(1, `SB_CTRL_OFF, 32'h4000_0000);
    wr(ln(7), 32'h1, 0, 9'h102);
    cyc(1);
    chk({nb, lb}, {k + 2, `SB_RESP_OKAY});
    $display("test responses finished");
    ahb(1, `SB_CTRL_OFF, 32'h0000_0001);
    cyc(8);
    k = nd;
    wr(ln(8), 32'h0, {8{32'hDEAD_BEEF}}, 9'h041);
    cyc(8);
    chk({nd, cs}, {k + 1, 32'hFFFF_FFFF});
    chk(cd, 256'h0);
    wr(ln(9), 32'h1, 0, 9'h070);
    rq(32'h8000_0000, 4'h4);
    cyc(4);
    chk(cf, 1'b1);
    k = na;
    l3r(RD_WA_FILL, `SB_RESP_DECERR);
    chk(na, k);
    l3r(RD_RA_FILL, `SB_RESP_SLVERR);
    chk({ns, lr, slv_irq, na}, {32'd1, `SB_RESP_SLVERR, 1'b1, k});
    l3r(RD_PREFETCH, `SB_RESP_OKAY);
    chk({ns, na}, {32'd1, k + 1});
    ahb(0, `SB_STATUS_OFF, 0);
    chk(q, 32'h0000_0300);
    ahb(1, `SB_IRQ_CLR_OFF, 32'h0000_0300);
    cyc(2);
    chk({slv_irq, dec_irq}, 2'h0);
    $display("test fills finished");
    give_verdict;
  end
endmodule : l2_store_buffer_hazard_errors_test

//--- testbench/l3_model.sv
// Purpose: far-side memory model that takes drains and returns write responses
// Assumes: one clock; a drain is accepted after lat extra cycles
// Notes: response lines wander while idle so a stale code is never mistaken for a new one
`timescale 1ns/1ns
module l3_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic drain_valid,
  output logic drain_ready,
  output logic l3_bvalid,
  output logic l3_b_slave,
  output logic [1:0] l3_bresp,
  input wire logic [3:0] lat,
  input wire logic [1:0] drn_resp,
  input wire logic slv_go,
  input wire logic [1:0] slv_resp
);
  logic [3:0] cnt_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      drain_ready <= 1'b0;
      l3_bvalid <= 1'b0;
      l3_b_slave <= 1'b0;
      l3_bresp <= 2'h0;
    end else begin
      drain_ready <= 1'b0;
      l3_bvalid <= 1'b0;
      l3_b_slave <= ~l3_b_slave;
      l3_bresp <= ~l3_bresp;
      if (drain_valid && !drain_ready) begin
        cnt_q <= (cnt_q >= lat) ? 4'h0 : cnt_q + 4'h1;
        drain_ready <= (cnt_q >= lat);
      end
      if (drain_ready) begin
        l3_bvalid <= 1'b1;
        l3_b_slave <= 1'b0;
        l3_bresp <= drn_resp;
      end else if (slv_go) begin
        l3_bvalid <= 1'b1;
        l3_b_slave <= 1'b1;
        l3_bresp <= slv_resp;
      end
    end
  end
endmodule : l3_model

//--- verilog/store_buffer.sv
// Purpose: three-slot merging store buffer with drain policy, hazard flags and L3 error return
// Assumes: one clock; slave ports present one write and one read request per cycle
// Notes: control registers over AHB-Lite, zero wait states, always OKAY
// How it works
// - a later write to the same address and security overwrites undrained data
// - writes to one line merge into one slot; slots wait for more writes
// - a slot holding a device-memory write is drained at once
// - a slot is drained once all its bytes are valid
// - strongly ordered reads or writes drain the whole buffer
// - with all three slots holding data the least recently used drains
// - a hazard against a slot drains that slot
// - a locked transaction on a slave port drains the slots
// - a configuration register access on a slave port drains the slots
// - merging needs equal line and security bit, and a slot not currently offered on the drain port
// - three 256-bit slots with byte valids, each with two address records
// - partial write-allocate drains ask for a linefill; errors block allocation
// - hazard compare uses address bits 20:5 or 31:5 by configuration
// - cacheable reads and writes are checked against the documented buffers
// - early write response on store buffer acceptance when enabled and user bit 11
// - prefetch hints return no data and allocate on a miss
// - with zero-line enabled, user bit 10 writes zero the whole line
// - non-bufferable writes without early response get the L3 response, bufferable ones OKAY
// - read-allocate fill errors skip allocation, return the error and raise an interrupt
// - drain and eviction write errors only raise an interrupt line
// - interrupt outputs are sticky
`timescale 1ns/1ns
`include "sb_consts.svh"
module store_buffer #(
  parameter bit WIDE_CMP = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_addr,
  input wire logic wr_secure,
  input wire logic [255:0] wr_data,
  input wire logic [31:0] wr_strb,
  input wire logic wr_device,
  input wire logic wr_strong,
  input wire logic wr_bufferable,
  input wire logic wr_cacheable,
  input wire logic write_allocate,
  input wire logic wr_locked,
  input wire logic wr_cfg,
  input wire logic wr_early,
  input wire logic wr_zero,
  output logic bresp_valid,
  output logic [1:0] bresp,
  input wire logic rd_valid,
  input wire logic [31:0] rd_addr,
  input wire logic rd_cacheable,
  input wire logic rd_strong,
  input wire logic rd_locked,
  input wire logic rd_cfg,
  input wire logic rslot_hit,
  input wire logic evict_hit,
  input wire logic mread_hit,
  output logic rd_hazard,
  output logic wr_hazard,
  output logic drain_valid,
  input wire logic drain_ready,
  output logic [26:0] drain_line,
  output logic drain_secure,
  output logic [255:0] drain_data,
  output logic [31:0] drain_strb,
  output logic drain_fill,
  input wire logic l3_bvalid,
  input wire logic l3_b_slave,
  input wire logic [1:0] l3_bresp,
  input wire logic l3_rvalid,
  input wire sb_pkg::rd_kind_type l3_rkind,
  input wire logic [1:0] l3_rresp,
  output logic s_rvalid,
  output logic [1:0] s_rresp,
  output logic alloc,
  output logic l3_slave_error_irq,
  output logic l3_decode_error_irq
);
  import sb_pkg::*;

  state_type q, n;
  logic ahb_take, flush, take, zero, found;
  logic [1:0] tgt, lru;
  logic [`SB_SLOTS-1:0] valid_v, drain_v, full_v;
  logic [1:0] b_err, r_err;

  // only line bits above the 32-byte offset are kept
  function automatic logic line_hit(input logic [26:0] a, input logic [26:0] b);
    return WIDE_CMP ? (a == b) : (a[15:0] == b[15:0]);
  endfunction : line_hit

  function automatic logic [1:0] err_bits(input logic [1:0] r);
    return {r == `SB_RESP_DECERR, r == `SB_RESP_SLVERR};
  endfunction : err_bits

  // decoded once here; the sticky flags below only ever OR them in
  assign b_err = err_bits(l3_bresp);
  assign r_err = err_bits(l3_rresp);

  always_comb begin
    n = q;
    n.bresp_valid = 1'b0;
    n.s_rvalid = 1'b0;
    n.alloc = 1'b0;
    n.rd_haz = 1'b0;
    n.wr_haz = 1'b0;
    zero = 1'b0;
    found = 1'b0;
    tgt = 2'h0;
    lru = 2'h0;
    // register data phase; clears first so that hardware sets below win
    if (q.hw_pend) begin
      case (q.hoff)
        `SB_CTRL_OFF: begin
          n.early_en = hwdata[`SB_EARLY_BIT];
          n.zero_en = hwdata[`SB_ZERO_BIT];
        end
        `SB_IRQ_CLR_OFF: begin
          if (hwdata[`SB_ST_SLV_BIT]) n.slv_irq = 1'b0;
          if (hwdata[`SB_ST_DEC_BIT]) n.dec_irq = 1'b0;
        end
        default: ;
      endcase
    end
    ahb_take = hsel && htrans[1] && hready;
    n.hw_pend = ahb_take && hwrite;
    n.hoff = haddr[7:0];
    // drain handshake frees the slot
    if (q.dv && drain_ready) begin
      n.dv = 1'b0;
      n.slot[q.didx] = '0;
    end
    // write acceptance: merge or allocate
    take = wr_valid && q.wr_ready;
    if (take) begin
      zero = q.zero_en && wr_zero;
      for (int i = 0; i < `SB_SLOTS; i++) begin
        if (!found && n.slot[i].valid && !(q.dv && q.didx == 2'(i)) && n.slot[i].sec == wr_secure &&
            n.slot[i].line == wr_addr[31:5]) begin
          found = 1'b1;
          tgt = 2'(i);
        end
      end
      for (int i = 0; i < `SB_SLOTS; i++) begin
        if (!found && !n.slot[i].valid) begin
          found = 1'b1;
          tgt = 2'(i);
          n.slot[i].strb = '0;
        end
      end
      n.slot[tgt].valid = 1'b1;
      n.slot[tgt].line = wr_addr[31:5];
      n.slot[tgt].sec = wr_secure;
      n.slot[tgt].last_line = wr_addr[31:5];
      n.slot[tgt].last_sec = wr_secure;
      n.slot[tgt].wa = n.slot[tgt].wa | (write_allocate && wr_cacheable);
      for (int b = 0; b < `SB_LINE_BYTES; b++) begin
        if (zero || wr_strb[b]) begin
          n.slot[tgt].data[b*8 +: 8] = zero ? 8'h00 : wr_data[b*8 +: 8];
          n.slot[tgt].strb[b] = 1'b1;
        end
      end
      if (wr_device) n.slot[tgt].drain = 1'b1;
      for (int i = 0; i < `SB_SLOTS; i++) begin
        if (2'(i) == tgt) n.slot[i].age = 2'h0;
        else if (n.slot[i].age != `SB_AGE_MAX) n.slot[i].age = n.slot[i].age + 2'h1;
      end
      // bufferable or early writes are answered here; others wait for L3
      if (wr_bufferable || (q.early_en && wr_early)) begin
        n.bresp_valid = 1'b1;
        n.bresp = `SB_RESP_OKAY;
      end
    end
    n.wr_haz = wr_valid && wr_cacheable && (evict_hit || mread_hit);
    n.rd_haz = rd_valid && rd_cacheable && (rslot_hit || evict_hit || mread_hit);
    // any strong, locked or config access empties the whole buffer
    flush = (wr_valid && (wr_strong || wr_locked || wr_cfg)) || (rd_valid && (rd_strong || rd_locked || rd_cfg));
    for (int i = 0; i < `SB_SLOTS; i++) begin
      if (n.slot[i].valid) begin
        if (flush) n.slot[i].drain = 1'b1;
        if (&n.slot[i].strb) n.slot[i].drain = 1'b1;
        if (rd_valid && rd_cacheable && (line_hit(n.slot[i].line, rd_addr[31:5]) ||
            line_hit(n.slot[i].last_line, rd_addr[31:5]))) begin
          n.slot[i].drain = 1'b1;
          n.rd_haz = 1'b1;
        end
        // ages saturate at three; a tie picks the higher slot
        if (n.slot[i].age >= n.slot[lru].age) lru = 2'(i);
      end
    end
    if (n.slot[0].valid && n.slot[1].valid && n.slot[2].valid) n.slot[lru].drain = 1'b1;
    // launch one drain at a time, lowest slot first
    for (int i = 0; i < `SB_SLOTS; i++) begin
      if (!n.dv && n.slot[i].valid && n.slot[i].drain) begin
        n.dv = 1'b1;
        n.didx = 2'(i);
        n.dline = n.slot[i].line;
        n.dsec = n.slot[i].sec;
        n.ddata = n.slot[i].data;
        n.dstrb = n.slot[i].strb;
        n.dfill = n.slot[i].wa && !(&n.slot[i].strb);
      end
    end
    // L3 write responses
    if (l3_bvalid) begin
      if (l3_b_slave) begin
        n.bresp_valid = 1'b1;
        n.bresp = l3_bresp;
      end else begin
        n.slv_irq = n.slv_irq | b_err[0];
        n.dec_irq = n.dec_irq | b_err[1];
      end
    end
    // L3 read returns
    if (l3_rvalid) begin
      case (l3_rkind)
        RD_SLAVE: begin
          n.s_rvalid = 1'b1;
          n.s_rresp = l3_rresp;
        end
        RD_RA_FILL: begin
          n.s_rvalid = 1'b1;
          n.s_rresp = l3_rresp;
          n.alloc = !l3_rresp[1];
          n.slv_irq = n.slv_irq | r_err[0];
          n.dec_irq = n.dec_irq | r_err[1];
        end
        RD_WA_FILL: begin
          n.alloc = !l3_rresp[1];
          n.slv_irq = n.slv_irq | r_err[0];
          n.dec_irq = n.dec_irq | r_err[1];
        end
        // a failed hint is simply dropped: no allocation and no interrupt
        RD_PREFETCH: n.alloc = !l3_rresp[1];
        default: ;
      endcase
    end
    // registered ready: a slot freed now is offered from the next cycle
    n.wr_ready = !(n.slot[0].valid && n.slot[1].valid && n.slot[2].valid);
    n.hrdata = 32'h0000_0000;
    if (ahb_take && !hwrite) begin
      case (haddr[7:0])
        `SB_CTRL_OFF: begin
          n.hrdata[`SB_EARLY_BIT] = n.early_en;
          n.hrdata[`SB_ZERO_BIT] = n.zero_en;
        end
        `SB_STATUS_OFF: begin
          n.hrdata[`SB_ST_VALID_LSB +: 3] = {n.slot[2].valid, n.slot[1].valid, n.slot[0].valid};
          n.hrdata[`SB_ST_DRAIN_BIT] = n.dv;
          n.hrdata[`SB_ST_SLV_BIT] = n.slv_irq;
          n.hrdata[`SB_ST_DEC_BIT] = n.dec_irq;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.hready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign hreadyout = q.hready;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign wr_ready = q.wr_ready;
  assign bresp_valid = q.bresp_valid;
  assign bresp = q.bresp;
  assign rd_hazard = q.rd_haz;
  assign wr_hazard = q.wr_haz;
  assign drain_valid = q.dv;
  assign drain_line = q.dline;
  assign drain_secure = q.dsec;
  assign drain_data = q.ddata;
  assign drain_strb = q.dstrb;
  assign drain_fill = q.dfill;
  assign s_rvalid = q.s_rvalid;
  assign s_rresp = q.s_rresp;
  assign alloc = q.alloc;
  assign l3_slave_error_irq = q.slv_irq;
  assign l3_decode_error_irq = q.dec_irq;

  // assertion helpers
  logic clr_slv;
  always_comb begin
    for (int i = 0; i < `SB_SLOTS; i++) begin
      valid_v[i] = q.slot[i].valid;
      drain_v[i] = q.slot[i].drain;
      full_v[i] = q.slot[i].valid && (&q.slot[i].strb);
    end
  end
  assign clr_slv = q.hw_pend && q.hoff == `SB_IRQ_CLR_OFF && hwdata[`SB_ST_SLV_BIT];

  // all properties share the bus clock and rest during reset
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  early_resp_a: assert property (wr_valid && wr_ready && q.early_en && wr_early |=> bresp_valid && bresp == 2'h0)
    else $error("early write response missing");
  device_drain_a: assert property (wr_valid && wr_ready && wr_device |=> (|(drain_v & valid_v)) || drain_valid)
    else $error("device write not marked for drain");
  full_drain_a: assert property ((full_v & ~drain_v) == 3'h0)
    else $error("full slot not draining");
  strong_flush_a: assert property (rd_valid && rd_strong |=> (valid_v & ~drain_v) == 3'h0)
    else $error("strongly ordered read did not flush");
  lru_drain_a: assert property (&valid_v |-> |drain_v)
    else $error("three full slots and none draining");
  ra_error_a: assert property (l3_rvalid && l3_rkind == RD_RA_FILL && l3_rresp[1]
      |=> s_rvalid && s_rresp == $past(l3_rresp) && !alloc)
    else $error("linefill error handled wrongly");
  drain_err_irq_a: assert property (l3_bvalid && !l3_b_slave && l3_bresp == 2'h2 |=> l3_slave_error_irq && !bresp_valid[*1])
    else $error("drain error did not raise interrupt");
  irq_sticky_a: assert property (l3_slave_error_irq && !clr_slv |=> l3_slave_error_irq)
    else $error("slave error interrupt dropped");
  prefetch_nodata_a: assert property (l3_rvalid && l3_rkind == RD_PREFETCH |=> !s_rvalid)
    else $error("prefetch hint returned data");
  nb_resp_a: assert property (l3_bvalid && l3_b_slave |=> bresp_valid && bresp == $past(l3_bresp))
    else $error("L3 write response not forwarded");
  write_hazard_a: assert property (wr_valid && wr_cacheable && evict_hit |=> wr_hazard)
    else $error("write hazard not flagged");

  drain_done_c: cover property (drain_valid && drain_ready);
  merge_c: cover property (wr_valid && wr_ready ##1 wr_valid && wr_ready && $stable(wr_addr) ##1 valid_v == 3'h1);
  zero_line_c: cover property (wr_valid && wr_ready && q.zero_en && wr_zero);
  fill_req_c: cover property (drain_valid && drain_fill);
  hazard_c: cover property (rd_hazard || wr_hazard);
endmodule : store_buffer
